// *** core/pix_fmt.sv ***
`timescale 1ns/1ps
module pix_fmt #(
  parameter int IDLE_CYC = pix_fmt_pkg::LINK_IDLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic in_valid,
  input wire logic [pix_fmt_pkg::COL_W-1:0] in_red,
  input wire logic [pix_fmt_pkg::COL_W-1:0] in_green,
  input wire logic [pix_fmt_pkg::COL_W-1:0] in_blue,
  input wire logic in_line_sync,
  input wire logic in_frame_sync,
  input wire logic in_active,
  input wire logic [pix_fmt_pkg::CTL_W-1:0] in_user_ctl,
  output logic pixel_out_clock,
  output logic [pix_fmt_pkg::PIX_W-1:0] even_pixel_bus,
  output logic [pix_fmt_pkg::PIX_W-1:0] odd_pixel_bus,
  output logic line_sync,
  output logic frame_sync,
  output logic active_video_flag,
  output logic [pix_fmt_pkg::CTL_W-1:0] user_control_outputs,
  output logic link_active_flag,
  output logic main_oe,
  output logic keep_oe
);
  import pix_fmt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state

  logic [CTRL_W-1:0] ctrl_q;
  logic [STAT_W-1:0] stat_s_q;
  logic [STAT_W-1:0] stat_m_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic hit;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == CTRL_ADDR) || (a == STATUS_ADDR);
  endfunction

  assign access = psel && penable && !pready_q;
  assign hit = addr_hit(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access;
      pslverr_q <= access && !hit;
      prdata_q <= 32'h0000_0000;
      if (access && !pwrite && paddr == CTRL_ADDR) begin
        prdata_q <= {{(32-CTRL_W){1'b0}}, ctrl_q};
      end else if (access && !pwrite && paddr == STATUS_ADDR) begin
        prdata_q <= {{(32-STAT_W){1'b0}}, stat_s_q};
      end
    end
  end

  // write lands at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (psel && penable && pready_q && pwrite &&
                 paddr == CTRL_ADDR) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  // link status into pclk domain
  logic [STAT_W-1:0] stat_l;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_m_q <= '0;
      stat_s_q <= '0;
    end else begin
      stat_m_q <= stat_l;
      stat_s_q <= stat_m_q;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////
  // link domain reset and control synchronisers

  logic lrst_m_q;
  logic lrst_n_q;
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lrst_m_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      lrst_m_q <= 1'b1;
      lrst_n_q <= lrst_m_q;
    end
  end

  logic [CTRL_W-1:0] ctl_m_q;
  logic [CTRL_W-1:0] ctl_s_q;
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      ctl_m_q <= CTRL_RESET;
      ctl_s_q <= CTRL_RESET;
    end else begin
      ctl_m_q <= ctrl_q;
      ctl_s_q <= ctl_m_q;
    end
  end

  logic edge_s;
  logic pix2_s;
  logic stagger_select_n_n_s;
  logic fpd_n_s;
  logic opd_n_s;
  logic stagger_select_n_on;
  assign edge_s = ctl_s_q[CTRL_EDGE_BIT];
  assign pix2_s = ctl_s_q[CTRL_WIDTH_BIT];
  assign stagger_select_n_n_s = ctl_s_q[CTRL_STAGGER_SELECT_N_BIT];
  assign fpd_n_s = ctl_s_q[CTRL_FPD_BIT];
  assign opd_n_s = ctl_s_q[CTRL_OPD_BIT];
  assign stagger_select_n_on = pix2_s && !stagger_select_n_n_s;

  ////////////////////////////////////////////////////////////////////////
  // pixel capture and pairing

  logic idx_q;
  logic [PIX_W-1:0] hold_q;
  logic [PIX_W-1:0] st_even_q;
  logic [PIX_W-1:0] st_odd_q;
  logic [PIX_W-1:0] in_pix;
  logic [PIX_W-1:0] st_odd_at_q;
  logic st_hs_q;
  logic st_vs_q;
  logic st_de_q;
  logic [CTL_W-1:0] st_ctl_q;

  // blue low byte, green middle, red high
  always_comb begin
    in_pix = '0;
    in_pix[BLUE_LSB +: COL_W] = in_blue;
    in_pix[GREEN_LSB +: COL_W] = in_green;
    in_pix[RED_LSB +: COL_W] = in_red;
  end

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      idx_q <= 1'b0;
      hold_q <= '0;
      st_even_q <= '0;
      st_odd_q <= '0;
    end else if (!fpd_n_s) begin
      idx_q <= 1'b0;
      hold_q <= '0;
      st_even_q <= '0;
      st_odd_q <= '0;
    end else if (in_valid) begin
      if (!in_active) begin
        idx_q <= 1'b0;
      end else begin
        idx_q <= !idx_q;
      end
      if (!pix2_s) begin
        st_even_q <= in_pix;
        st_odd_q <= '0;
      end else if (!in_active) begin
        st_even_q <= in_pix;
        st_odd_q <= '0;
      end else if (!idx_q) begin
        hold_q <= in_pix;
      end else begin
        st_even_q <= hold_q;
        st_odd_q <= in_pix;
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      st_hs_q <= 1'b0;
      st_vs_q <= 1'b0;
      st_de_q <= 1'b0;
      st_ctl_q <= '0;
    end else if (!fpd_n_s) begin
      st_hs_q <= 1'b0;
      st_vs_q <= 1'b0;
      st_de_q <= 1'b0;
      st_ctl_q <= '0;
    end else if (in_valid && (!pix2_s || !in_active || idx_q)) begin
      st_hs_q <= in_line_sync;
      st_vs_q <= in_frame_sync;
      st_de_q <= in_active;
      st_ctl_q <= in_user_ctl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output clock and launch timing

  logic [PH_W-1:0] ph_q;
  logic [PH_W-1:0] ph_d;
  logic oclk_q;
  logic new_clk;
  logic launch;
  logic launch_q;
  logic odd_upd;

  assign ph_d = ph_q + PH_W'(1);
  assign new_clk = pix2_s ? ph_d[1] : ph_d[0];
  // launch on the edge opposite the capturing one
  assign launch = fpd_n_s && (new_clk != oclk_q) &&
                  (new_clk != edge_s);
  assign odd_upd = stagger_select_n_on ? launch_q : launch;

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      ph_q <= '0;
      oclk_q <= 1'b0;
      launch_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      oclk_q <= fpd_n_s && new_clk;
      launch_q <= launch;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output registers

  logic [PIX_W-1:0] even_q;
  logic [PIX_W-1:0] odd_q;
  logic hs_q;
  logic vs_q;
  logic de_q;
  logic [CTL_W-1:0] uctl_q;

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      even_q <= '0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      de_q <= 1'b0;
      uctl_q <= '0;
      st_odd_at_q <= '0;
    end else if (!fpd_n_s) begin
      even_q <= '0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      de_q <= 1'b0;
      uctl_q <= '0;
      st_odd_at_q <= '0;
    end else if (launch) begin
      even_q <= st_even_q;
      st_odd_at_q <= st_odd_q;
      hs_q <= st_hs_q;
      vs_q <= st_vs_q;
      de_q <= st_de_q;
      uctl_q <= st_ctl_q;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      odd_q <= '0;
    end else if (!pix2_s || !fpd_n_s) begin
      odd_q <= '0;
    end else if (odd_upd) begin
      odd_q <= stagger_select_n_on ? st_odd_at_q : st_odd_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link activity from active-video edges

  logic [$clog2(IDLE_CYC+1)-1:0] idle_q;
  logic prev_de_q;
  logic link_q;

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      idle_q <= '0;
      prev_de_q <= 1'b0;
      link_q <= 1'b0;
    end else if (!fpd_n_s) begin
      idle_q <= '0;
      prev_de_q <= 1'b0;
      link_q <= 1'b0;
    end else begin
      if (in_valid) begin
        prev_de_q <= in_active;
      end
      if (in_valid && in_active != prev_de_q) begin
        idle_q <= '0;
        link_q <= 1'b1;
      end else if (idle_q == ($clog2(IDLE_CYC+1))'(IDLE_CYC)) begin
        link_q <= 1'b0;
      end else begin
        idle_q <= idle_q + 1'b1;
      end
    end
  end

  always_comb begin
    stat_l = '0;
    stat_l[STAT_LINK_BIT] = link_q;
    stat_l[STAT_FPD_BIT] = !fpd_n_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // output enables

  logic main_oe_q;
  logic keep_oe_q;
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      main_oe_q <= 1'b0;
      keep_oe_q <= 1'b0;
    end else begin
      main_oe_q <= fpd_n_s && opd_n_s;
      keep_oe_q <= fpd_n_s;
    end
  end

  assign pixel_out_clock = oclk_q;
  assign even_pixel_bus = even_q;
  assign odd_pixel_bus = odd_q;
  assign line_sync = hs_q;
  assign frame_sync = vs_q;
  assign active_video_flag = de_q;
  assign user_control_outputs = uctl_q;
  assign link_active_flag = link_q;
  assign main_oe = main_oe_q;
  assign keep_oe = keep_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_clk_high2;
    oclk_q ##1 oclk_q;
  endsequence

  property p_pd_tristate;
    @(posedge link_clk) disable iff (!lrst_n_q)
    !fpd_n_s |=> !main_oe_q && !keep_oe_q;
  endproperty
  a_pd_tristate: assert property (p_pd_tristate)
    else $error("outputs driven in full power-down");

  property p_pd_ignore;
    @(posedge link_clk) disable iff (!lrst_n_q)
    !fpd_n_s ##1 !fpd_n_s |-> even_q == '0 && !link_q && !oclk_q;
  endproperty
  a_pd_ignore: assert property (p_pd_ignore)
    else $error("activity during full power-down");

  property p_opd_keep;
    @(posedge link_clk) disable iff (!lrst_n_q)
    fpd_n_s && !opd_n_s |=> !main_oe_q && keep_oe_q;
  endproperty
  a_opd_keep: assert property (p_opd_keep)
    else $error("output power-down enables wrong");

  property p_rise_capture;
    @(posedge link_clk) disable iff (!lrst_n_q)
    edge_s && $stable(edge_s) && $stable(pix2_s) && $changed(even_q)
    && $past(fpd_n_s)
    |-> !oclk_q && $past(oclk_q);
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("data not launched on falling clock");

  property p_fall_capture;
    @(posedge link_clk) disable iff (!lrst_n_q)
    !edge_s && $stable(edge_s) && $stable(pix2_s) && $changed(even_q)
    && $past(fpd_n_s)
    |-> oclk_q && !$past(oclk_q);
  endproperty
  a_fall_capture: assert property (p_fall_capture)
    else $error("data not launched on rising clock");

  property p_one_pix_odd_low;
    @(posedge link_clk) disable iff (!lrst_n_q)
    !pix2_s |=> odd_q == '0;
  endproperty
  a_one_pix_odd_low: assert property (p_one_pix_odd_low)
    else $error("odd bus not low in one-pixel mode");

  property p_half_rate;
    @(posedge link_clk) disable iff (!lrst_n_q)
    fpd_n_s && pix2_s && $stable(pix2_s) && $rose(oclk_q)
    |-> s_clk_high2 ##1 !oclk_q;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("two-pixel clock period wrong");

  property p_line_start_even;
    @(posedge link_clk) disable iff (!lrst_n_q)
    fpd_n_s && in_valid && !in_active |=> !idx_q;
  endproperty
  a_line_start_even: assert property (p_line_start_even)
    else $error("line does not start on even pixel");

  property p_stagger;
    @(posedge link_clk) disable iff (!lrst_n_q)
    stagger_select_n_on && $stable(ctl_s_q) && fpd_n_s && $changed(odd_q)
    |-> $stable(oclk_q);
  endproperty
  a_stagger: assert property (p_stagger)
    else $error("odd bus not staggered");

  property p_together;
    @(posedge link_clk) disable iff (!lrst_n_q)
    pix2_s && !stagger_select_n_on && $stable(ctl_s_q) && fpd_n_s && $changed(odd_q)
    |-> $changed(oclk_q);
  endproperty
  a_together: assert property (p_together)
    else $error("odd bus not launched with even bus");

endmodule

// *** core/pix_fmt_pkg.sv ***
// Contract
// - edge select high: capture on rising clock
// - edge select low: capture on falling clock
// - full power-down tri-states every output
// - full power-down ignores all other inputs
// - full power-down control defaults to running
// - output power-down keeps link flag, first control
// - output power-down control defaults drivers on
// - two-pixel mode: even and odd together
// - one-pixel mode: every pixel on even bus
// - pixel index restarts even at line start
// - even bus blue low, green mid, red high
// - odd bus same colour layout as even
// - one-pixel mode drives odd bus low
// - pixel buses change only with output clock (staggered odd bus changes one link cycle after it)
// - active video flag high only in display
// - two-pixel stagger when stagger select low
package pix_fmt_pkg;

  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;

  // control register fields
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_WIDTH_BIT = 1;
  localparam int CTRL_STAGGER_SELECT_N_BIT = 2;
  localparam int CTRL_FPD_BIT = 3;
  localparam int CTRL_OPD_BIT = 4;
  localparam int CTRL_W = 5;
  // edge rising, one pixel, no stagger, both power-downs released
  localparam logic [4:0] CTRL_RESET = 5'h1D;

  // status register fields
  localparam int STAT_LINK_BIT = 0;
  localparam int STAT_FPD_BIT = 1;
  localparam int STAT_W = 2;

  // colour fields of a 24-bit pixel bus
  localparam int PIX_W = 24;
  localparam int COL_W = 8;
  localparam int BLUE_LSB = 0;
  localparam int GREEN_LSB = 8;
  localparam int RED_LSB = 16;

  localparam int CTL_W = 3;
  localparam int PH_W = 2;

  // link cycles without an active-video edge before link is idle
  localparam int LINK_IDLE_CYC = 1024;

endpackage

// *** dv/pix_sink.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module pix_sink (
  input wire logic pixel_out_clock,
  input wire logic edge_sel,
  input wire logic drive_on,
  input wire logic active_video_flag,
  input wire logic [pix_fmt_pkg::PIX_W-1:0] even_pixel_bus,
  input wire logic [pix_fmt_pkg::PIX_W-1:0] odd_pixel_bus
);
  import pix_fmt_pkg::*;
  logic [2*PIX_W-1:0] cap_log[$];
  // panel latches on the selected edge, active video only
  always @(posedge pixel_out_clock) begin
    if (edge_sel && drive_on && active_video_flag) begin
      cap_log.push_back({odd_pixel_bus, even_pixel_bus});
    end
  end
  always @(negedge pixel_out_clock) begin
    if (!edge_sel && drive_on && active_video_flag) begin
      cap_log.push_back({odd_pixel_bus, even_pixel_bus});
    end
  end
endmodule

// *** dv/test_dvi_rx_pixel_output_formatter.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
////////////////////////////////////////////////////////////////////////
module test_dvi_rx_pixel_output_formatter;
  import pix_fmt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, link_clk, in_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, edge_sel;
  logic [23:0] pix;
  logic in_ls, in_fs, in_act;
  logic [2:0] in_ctl;
  logic pixel_out_clock, line_sync, frame_sync, active_video_flag;
  logic link_active_flag, main_oe, keep_oe;
  logic [23:0] even_pixel_bus, odd_pixel_bus;
  logic [2:0] user_control_outputs;
  logic [15:0] seed;
  int error_cnt, comparisons, cyc;

  pix_fmt #(.IDLE_CYC(16)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .in_valid(in_valid), .in_red(pix[23:16]),
    .in_green(pix[15:8]), .in_blue(pix[7:0]), .in_line_sync(in_ls),
    .in_frame_sync(in_fs), .in_active(in_act), .in_user_ctl(in_ctl),
    .pixel_out_clock(pixel_out_clock), .even_pixel_bus(even_pixel_bus),
    .odd_pixel_bus(odd_pixel_bus), .line_sync(line_sync),
    .frame_sync(frame_sync), .active_video_flag(active_video_flag),
    .user_control_outputs(user_control_outputs),
    .link_active_flag(link_active_flag), .main_oe(main_oe),
    .keep_oe(keep_oe));

  pix_sink sink_u (.pixel_out_clock(pixel_out_clock), .edge_sel(edge_sel),
    .drive_on(main_oe), .active_video_flag(active_video_flag),
    .even_pixel_bus(even_pixel_bus), .odd_pixel_bus(odd_pixel_bus));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one sample, then released lines show the inverse
  task automatic send(input logic [23:0] px, input logic act);
    @(posedge link_clk);
    in_valid <= 1'b1;
    pix <= px;
    in_act <= act;
    in_ls <= ~act;
    in_fs <= px[3];
    in_ctl <= px[2:0];
    @(posedge link_clk);
    in_valid <= 1'b0;
    pix <= ~px;
    in_act <= ~act;
    in_ls <= act;
    in_fs <= ~px[3];
    in_ctl <= ~px[2:0];
  endtask

  task automatic set_ctrl(input logic [4:0] v);
    apb(1'b1, CTRL_ADDR, {27'h0, v});
    edge_sel = v[CTRL_EDGE_BIT];
    repeat (4) send(24'h0, 1'b0);
  endtask

  // one line of active video, then compare what the panel latched
  task automatic burst(input int n, input logic two);
    logic [23:0] sent[$];
    logic [23:0] px;
    sink_u.cap_log.delete();
    for (int i = 0; i < n; i++) begin
      seed = lfsr_next(seed);
      px = {seed, seed[11:4]};
      if (i == 0) px = 24'h0000FF;
      if (i == 1) px = 24'hFF0000;
      sent.push_back(px);
      send(px, 1'b1);
    end
    repeat (6) send(24'h0, 1'b0);
    if (two) begin
      `CHK(sink_u.cap_log.size(), n / 2)
      for (int k = 0; k < n / 2; k++) begin
        `CHK(sink_u.cap_log[k], {sent[2*k+1], sent[2*k]})
      end
    end else begin
      `CHK(sink_u.cap_log.size(), n)
      for (int k = 0; k < n; k++) begin
        `CHK(sink_u.cap_log[k], {24'h0, sent[k]})
      end
    end
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, in_valid, in_ls, in_fs, in_act} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pix = 24'h0;
    in_ctl = 3'h0;
    edge_sel = 1'b1;
    seed = 16'h002D;
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0);
    `CHK(rd, 32'h0000001D)
    apb(1'b0, 8'h08, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    set_ctrl(5'h1D);
    burst(9, 1'b0);
    send(24'h00000D, 1'b0);
    send(24'h00000D, 1'b0);
    repeat (3) @(posedge link_clk);
    `CHK({active_video_flag, line_sync, frame_sync, user_control_outputs}, 6'h1D)
    set_ctrl(5'h1C);
    burst(8, 1'b0);
    set_ctrl(5'h1F);
    burst(8, 1'b1);
    set_ctrl(5'h1B);
    burst(10, 1'b1);
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[STAT_LINK_BIT], 1'b1)
    `CHK(link_active_flag, 1'b1)
    repeat (12) send(24'h0, 1'b0);
    `CHK(link_active_flag, 1'b0)
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[STAT_LINK_BIT], 1'b0)
    set_ctrl(5'h0D);
    `CHK({main_oe, keep_oe}, 2'b01)
    set_ctrl(5'h15);
    send(24'hABCDEF, 1'b1);
    send(24'h123456, 1'b1);
    `CHK({main_oe, keep_oe, active_video_flag}, 3'b000)
    `CHK(even_pixel_bus, 24'h0)
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[STAT_FPD_BIT], 1'b1)
    set_ctrl(5'h1D);
    `CHK({main_oe, keep_oe}, 2'b11)
    burst(6, 1'b0);
    close_out();
  end
endmodule
